// ===== rtl/mmd_pkg.sv
// Package of offsets, reset values and region bounds for the memory map decoder
package mmd_pkg;

  // Bus geometry: one byte register per aligned 32-bit word
  localparam int          MMD_ADDR_LSB   = 2;
  localparam int          MMD_ADDR_MSB   = 17;
  localparam int          MMD_REG_COUNT  = 32;

  // Register indexes, byte address is four times the index
  localparam logic [15:0] MMD_PORT_A_DATA      = 16'h0000;
  localparam logic [15:0] MMD_PORT_A_DIRECTION = 16'h0001;
  localparam logic [15:0] MMD_PORT_A_OPTIONS   = 16'h0002;
  localparam logic [15:0] MMD_PORT_B_DATA      = 16'h0003;
  localparam logic [15:0] MMD_PORT_B_DIRECTION = 16'h0004;
  localparam logic [15:0] MMD_PORT_C_DATA      = 16'h0006;
  localparam logic [15:0] MMD_PORT_C_DIRECTION = 16'h0007;
  localparam logic [15:0] MMD_PORT_C_OPTIONS   = 16'h0008;
  localparam logic [15:0] MMD_PORT_D_DATA      = 16'h0009;
  localparam logic [15:0] MMD_PORT_D_DIRECTION = 16'h000A;
  localparam logic [15:0] MMD_PORT_D_OPTIONS   = 16'h000B;
  localparam logic [15:0] MMD_PORT_E_DATA      = 16'h000C;
  localparam logic [15:0] MMD_PORT_E_DIRECTION = 16'h000D;
  localparam logic [15:0] MMD_PORT_E_OPTIONS   = 16'h000E;
  localparam logic [15:0] MMD_PORT_F_DATA      = 16'h000F;
  localparam logic [15:0] MMD_PORT_F_DIRECTION = 16'h0010;
  localparam logic [15:0] MMD_CONVERTER_RESULT = 16'h0012;
  localparam logic [15:0] MMD_CONVERTER_CTRL   = 16'h0013;
  localparam logic [15:0] MMD_WATCHDOG_CONTROL = 16'h0014;
  localparam logic [15:0] MMD_POWER_CONTROL    = 16'h0018;
  localparam logic [15:0] MMD_SPI_DATA         = 16'h0019;
  localparam logic [15:0] MMD_SPI_CONTROL      = 16'h001A;
  localparam logic [15:0] MMD_SPI_CTRL_STATUS  = 16'h001B;
  localparam logic [15:0] MMD_COPROC_CONTROL   = 16'h001C;
  localparam logic [15:0] MMD_COPROC_STATUS    = 16'h001D;
  localparam logic [15:0] MMD_COPROC_POINTER   = 16'h001F;

  // Per-index masks over the first 32 register slots
  localparam logic [31:0] MMD_IMPL_MASK  = 32'hBF1DFFDF;
  localparam logic [31:0] MMD_WRITE_MASK = 32'hBF19FFDF;

  // Reset values
  localparam logic [7:0]  MMD_RESET_ZERO     = 8'h00;
  localparam logic [7:0]  MMD_RESET_WATCHDOG = 8'h7F;

  // Memory map regions
  localparam logic [15:0] MMD_REG_AREA_TOP = 16'h004F;
  localparam logic [15:0] MMD_STACK_BASE   = 16'h0100;
  localparam logic [15:0] MMD_STACK_TOP    = 16'h01FF;
  localparam logic [15:0] MMD_VECTOR_BASE  = 16'hFFE0;

  // Field positions
  localparam int          MMD_PE5_BIT          = 5;
  localparam int          MMD_PF4_BIT          = 4;
  localparam int          MMD_CARD_ONE_BIT     = 6;
  localparam int          MMD_CARD_TWO_BIT     = 7;
  localparam int          MMD_COPROC_EN_BIT    = 0;
  localparam int          MMD_COPROC_A_LINES   = 6;

  // Bus slave states
  typedef enum logic [0:0] {MMD_IDLE, MMD_DATA} mmd_state_t;

  // Reset value of one register slot
  function automatic logic [7:0] mmd_reset_value(input int idx);
    if (idx == int'(MMD_WATCHDOG_CONTROL)) begin
      return MMD_RESET_WATCHDOG;
    end
    return MMD_RESET_ZERO;
  endfunction : mmd_reset_value

endpackage : mmd_pkg

// ===== rtl/mmd_decoder.sv
// AHB-Lite register bank and address decoder for the lower memory map
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Decode one flat 64 Kbyte space of memory and registers, no banking.
// - Bottom 80 bytes are hardware registers, apart from RAM and program memory.
// - Stack window is RAM from 0100h to 01FFh, 256 bytes.
// - Topmost bytes hold reset and interrupt vectors, flagged on access.
// - At 6 MHz standalone the core cannot read or write the USB buffer.
// - Port registers from 0000h are read-write and clear to 00h on reset.
// - Port E option register sits at 000Eh and resets to 00h.
// - Port E bit 5 pull-up only when option register and option byte allow.
// - Converter control at 0013h read-write, result at 0012h read-only.
// - Serial data register at 0019h is read-write, reset content undefined.
// - With USB power enable disabled, port F bit 4 is plain I/O.
// - Card enable and protect lines are software pins; the rest coprocessor lines.
module mmd_decoder (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Option byte and operating mode
  input  wire logic                  option_pullup_bit,
  input  wire logic                  option_usb_power,
  input  wire logic                  standalone_6mhz,
  // Peripheral inputs
  input  wire logic [7:0]            converter_result,
  input  wire logic                  usb_power_request,
  input  wire logic [mmd_pkg::MMD_COPROC_A_LINES-1:0] coproc_a_out,
  input  wire logic [mmd_pkg::MMD_COPROC_A_LINES-1:0] coproc_a_oe_b,
  input  wire logic [7:0]            coproc_b_out,
  input  wire logic [7:0]            coproc_b_oe_b,
  // Port pins
  output logic      [7:0]            port_a_pin_out,
  output logic      [7:0]            port_a_pin_oe_b,
  output logic      [7:0]            port_b_pin_out,
  output logic      [7:0]            port_b_pin_oe_b,
  output logic      [7:0]            port_f_pin_out,
  output logic      [7:0]            port_f_pin_oe_b,
  output logic                       port_e_bit5_pullup,
  output logic                       card_enable_one,
  output logic                       card_enable_two,
  // Access region flags
  output logic                       hit_register,
  output logic                       hit_stack,
  output logic                       hit_vector,
  output logic                       hit_reserved,
  output logic                       usb_buffer_blocked
);
  import mmd_pkg::*;

  // Overview of the data path:
  // - The bus side accepts one single transfer at a time and always inserts
  //   exactly one wait state, so read data and flags leave flip-flops.
  // - The memory map address is the word index haddr[17:2]; each register
  //   takes the low byte lane of one aligned 32-bit word.
  // - Only the first 32 slots of the register area are stored here; the
  //   rest of the 80-byte area belongs to other blocks and reads zero.
  // - Region flags pulse for one cycle at the end of every data phase so
  //   that a monitor can see which part of the map was touched.
  // - Pin steering sits behind one more flop stage, so a register write
  //   reaches the pins one cycle after the bus answer.
  //
  // Limitations a user must know:
  // - hsize is not checked; a wider write still lands its low byte.
  // - No error response is ever given, reserved slots simply read zero.
  // - RAM, stack, program memory and vectors are not stored; only stack and vectors are flagged.
  // - The USB buffer window is a board parameter and is never served here.

  // USB buffer window; placement is board specific
  parameter logic [15:0] USB_BUF_BASE = 16'h1500;
  parameter logic [15:0] USB_BUF_TOP  = 16'h17FF;

  //////////////////////////////////////////////////////////////////////////////
  // Address phase decode

  logic [15:0] phase_addr;
  logic        phase_take;
  logic [15:0] map_addr;
  logic [4:0]  map_idx;
  logic        in_reg_slots;

  // The request is taken only while the slave is idle. Because hreadyout
  // is low during the single wait state, a well-behaved master cannot
  // present a new address phase then, so no second request is lost.
  //
  // Upper haddr bits are ignored on purpose: a master that places the
  // space above 256 KB sees the same map again, which keeps the decode
  // small and matches a flat space with no banking.
  //
  // phase_addr is the map address during the address phase; map_addr
  // holds it through the data phase, when haddr may already have moved.

  // Only haddr[17:2] is used, so the 64 KB map has no banking
  assign phase_addr = haddr[MMD_ADDR_MSB:MMD_ADDR_LSB];
  assign phase_take = hsel & hready & htrans[1];

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave state

  mmd_state_t  state;
  mmd_state_t  next_state;
  logic        pend_write;
  logic        next_pend_write;
  logic [15:0] next_map_addr;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  logic        next_hit_register;
  logic        next_hit_stack;
  logic        next_hit_vector;
  logic        next_hit_reserved;
  logic        next_usb_blocked;
  logic        usb_hit;
  logic        wr_strobe;
  logic [7:0]  reg_q [MMD_REG_COUNT];

  assign map_idx      = map_addr[4:0];
  assign in_reg_slots = (map_addr < 16'(MMD_REG_COUNT));
  assign usb_hit      = (map_addr >= USB_BUF_BASE) && (map_addr <= USB_BUF_TOP);

  // Sequence of one transfer:
  //   edge 0: address phase taken, hreadyout falls
  //   edge 1: write lands or read data loads, flags are registered
  //   edge 2: master samples hready high and takes hrdata
  //
  // Read data is held after the transfer, so a late sampler still sees
  // the last value; it only changes at the end of the next data phase.
  //
  // Flags default to zero each cycle, so they stand exactly one cycle.
  // Reserved decoding is limited to the 32 local slots; higher register
  // addresses belong to other blocks and are not judged here.
  //
  // The converter result is read live from its input, not from a slot,
  // so software always sees the latest conversion.

  // One wait state lets read data leave a flip-flop
  always_comb begin
    next_state        = state;
    next_pend_write   = pend_write;
    next_map_addr     = map_addr;
    next_hrdata       = hrdata;
    next_hreadyout    = hreadyout;
    next_hit_register = 1'b0;
    next_hit_stack    = 1'b0;
    next_hit_vector   = 1'b0;
    next_hit_reserved = 1'b0;
    next_usb_blocked  = 1'b0;
    wr_strobe         = 1'b0;
    case (state)
      MMD_IDLE: begin
        next_hreadyout = 1'b1;
        if (phase_take) begin
          next_state      = MMD_DATA;
          next_pend_write = hwrite;
          next_map_addr   = phase_addr;
          next_hreadyout  = 1'b0;
        end
      end
      MMD_DATA: begin
        next_state     = MMD_IDLE;
        next_hreadyout = 1'b1;
        next_hrdata    = 32'h0000_0000;
        wr_strobe      = pend_write;
        next_hit_register = (map_addr <= MMD_REG_AREA_TOP);
        next_hit_stack    = (map_addr >= MMD_STACK_BASE) && (map_addr <= MMD_STACK_TOP);
        next_hit_vector   = (map_addr >= MMD_VECTOR_BASE);
        next_hit_reserved = in_reg_slots && !MMD_IMPL_MASK[map_idx];
        next_usb_blocked  = usb_hit && standalone_6mhz;
        if (!pend_write) begin
          if (in_reg_slots && MMD_IMPL_MASK[map_idx]) begin
            if (map_addr == MMD_CONVERTER_RESULT) begin
              next_hrdata = {24'h000000, converter_result};
            end else begin
              next_hrdata = {24'h000000, reg_q[map_idx]};
            end
          end
        end
      end
      default: begin
        next_state = MMD_IDLE;
      end
    endcase
  end

  // All bus-facing outputs come straight from these flops. The reset
  // values leave the slave idle and ready, so the first request may be
  // taken at the first edge after reset is released.
  //
  // hresp is registered although it is constant, so every output of the
  // block has the same launch timing.

  // Slave registers; the response is always OKAY
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state              <= MMD_IDLE;
      pend_write         <= 1'b0;
      map_addr           <= 16'h0000;
      hrdata             <= 32'h0000_0000;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      hit_register       <= 1'b0;
      hit_stack          <= 1'b0;
      hit_vector         <= 1'b0;
      hit_reserved       <= 1'b0;
      usb_buffer_blocked <= 1'b0;
    end else begin
      state              <= next_state;
      pend_write         <= next_pend_write;
      map_addr           <= next_map_addr;
      hrdata             <= next_hrdata;
      hreadyout          <= next_hreadyout;
      hresp              <= 1'b0;
      hit_register       <= next_hit_register;
      hit_stack          <= next_hit_stack;
      hit_vector         <= next_hit_vector;
      hit_reserved       <= next_hit_reserved;
      usb_buffer_blocked <= next_usb_blocked;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file, one byte per slot

  // One generate slice per slot keeps the write enables independent.
  // Slots that are reserved or read-only never take a write strobe, so
  // their content stays at the reset value for good.
  //
  // The write uses the data phase, one cycle after the address phase, so
  // hwdata is sampled when the master has placed it.
  //
  // Every slot except the watchdog control, which loads 7Fh, clears on reset,
  // the serial ones included; software must still treat the serial data content as undefined after reset.

  // Only the low byte lane is stored; hsize is not checked, so wider writes
  // still land their low byte here
  genvar gi;
  generate
    for (gi = 0; gi < MMD_REG_COUNT; gi++) begin : g_slot
      logic [7:0] next_slot;
      always_comb begin
        next_slot = reg_q[gi];
        if (wr_strobe && in_reg_slots && (map_idx == 5'(gi)) && MMD_WRITE_MASK[gi]) begin
          next_slot = hwdata[7:0];
        end
      end
      // Serial data also clears, although software must not rely on it
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          reg_q[gi] <= mmd_reset_value(gi);
        end else begin
          reg_q[gi] <= next_slot;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Pin steering

  logic [7:0] next_a_out;
  logic [7:0] next_a_oe_b;
  logic [7:0] next_b_out;
  logic [7:0] next_b_oe_b;
  logic [7:0] next_f_out;
  logic [7:0] next_f_oe_b;
  logic       next_pullup;
  logic       coproc_on;
  logic [7:0] reg_a_data;
  logic [7:0] reg_a_dir;
  logic [7:0] reg_b_data;
  logic [7:0] reg_b_dir;
  logic [7:0] reg_f_data;
  logic [7:0] reg_f_dir;
  logic [7:0] reg_e_opt;

  assign reg_a_data = reg_q[MMD_PORT_A_DATA[4:0]];
  assign reg_a_dir  = reg_q[MMD_PORT_A_DIRECTION[4:0]];
  assign reg_b_data = reg_q[MMD_PORT_B_DATA[4:0]];
  assign reg_b_dir  = reg_q[MMD_PORT_B_DIRECTION[4:0]];
  assign reg_f_data = reg_q[MMD_PORT_F_DATA[4:0]];
  assign reg_f_dir  = reg_q[MMD_PORT_F_DIRECTION[4:0]];
  assign reg_e_opt  = reg_q[MMD_PORT_E_OPTIONS[4:0]];
  assign coproc_on  = reg_q[MMD_COPROC_CONTROL[4:0]][MMD_COPROC_EN_BIT];

  // Port A and B steering follows one rule: when the coprocessor is enabled it
  // owns port A bits 0 to 5 and all of port B; the two top bits of port
  // A stay with software so that it can pick one of two shared cards.
  //
  // Output enables are active low: a set direction bit drives the pin.
  //
  // Port F bit 4 is handed to the USB power request only when the option
  // byte asks for it; otherwise it is an ordinary I/O line.

  // Coprocessor owns strobe, address and data lines; card enables stay with software
  always_comb begin
    next_a_out  = reg_a_data;
    next_a_oe_b = ~reg_a_dir;
    next_b_out  = reg_b_data;
    next_b_oe_b = ~reg_b_dir;
    if (coproc_on) begin
      next_a_out[MMD_COPROC_A_LINES-1:0]  = coproc_a_out;
      next_a_oe_b[MMD_COPROC_A_LINES-1:0] = coproc_a_oe_b;
      next_b_out  = coproc_b_out;
      next_b_oe_b = coproc_b_oe_b;
    end
    next_f_out  = reg_f_data;
    next_f_oe_b = ~reg_f_dir;
    if (option_usb_power) begin
      next_f_out[MMD_PF4_BIT]  = usb_power_request;
      next_f_oe_b[MMD_PF4_BIT] = 1'b0;
    end
    // Pull-up needs both the option register and the option byte
    next_pullup = reg_e_opt[MMD_PE5_BIT] & option_pullup_bit;
  end

  // During reset every pin is released (oe_b high) and drives zero, so
  // the board's own pull resistors decide the level until software runs, except port F bit 4 when the option byte gives it to USB power.
  //
  // Card enables are plain copies of port A data bits 6 and 7; the cost
  // of one flop each buys a clean, separately observable select line.

  // Pin flops keep outputs glitch free
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_pin_out     <= 8'h00;
      port_a_pin_oe_b    <= 8'hFF;
      port_b_pin_out     <= 8'h00;
      port_b_pin_oe_b    <= 8'hFF;
      port_f_pin_out     <= 8'h00;
      port_f_pin_oe_b    <= 8'hFF;
      port_e_bit5_pullup <= 1'b0;
      card_enable_one    <= 1'b0;
      card_enable_two    <= 1'b0;
    end else begin
      port_a_pin_out     <= next_a_out;
      port_a_pin_oe_b    <= next_a_oe_b;
      port_b_pin_out     <= next_b_out;
      port_b_pin_oe_b    <= next_b_oe_b;
      port_f_pin_out     <= next_f_out;
      port_f_pin_oe_b    <= next_f_oe_b;
      port_e_bit5_pullup <= next_pullup;
      card_enable_one    <= reg_a_data[MMD_CARD_ONE_BIT];
      card_enable_two    <= reg_a_data[MMD_CARD_TWO_BIT];
    end
  end

endmodule : mmd_decoder

// ===== dv/mmd_decoder_properties.sv
// Concurrent checks on the decoder's bus answer, region flags and pins
`timescale 1ns/1ps
module mmd_decoder_checker #(
  parameter logic [15:0] USB_BUF_BASE = 16'h1500,
  parameter logic [15:0] USB_BUF_TOP  = 16'h17FF
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Mode and pins
  input wire logic        option_pullup_bit,
  input wire logic        standalone_6mhz,
  input wire logic        port_e_bit5_pullup,
  // Region flags
  input wire logic        hit_register,
  input wire logic        hit_stack,
  input wire logic        hit_vector,
  input wire logic        hit_reserved,
  input wire logic        usb_buffer_blocked
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Decoded request, taken only while the slave is idle
  wire [15:0] a    = haddr[17:2];
  wire        take = hsel && hready && htrans[1] && hreadyout;
  wire        rsv  = (a == 16'h0005) || (a == 16'h0011) || (a >= 16'h0015 && a <= 16'h0017) || (a == 16'h001E);
  wire        usb  = (a >= USB_BUF_BASE) && (a <= USB_BUF_TOP) && standalone_6mhz;
  // Exactly one wait state, then ready again
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_one_wait: assert property (take |=> s_wait) else $error("wait state count wrong");
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_reg_flag: assert property (take |-> ##2 (hit_register == $past(a <= 16'h004F, 2))) else $error("register flag");
  a_stack_flag: assert property (take |-> ##2 (hit_stack == $past(a[15:8] == 8'h01, 2))) else $error("stack flag");
  a_vector_flag: assert property (take |-> ##2 (hit_vector == $past(a >= 16'hFFE0, 2))) else $error("vector flag");
  a_hole_flag: assert property (take |-> ##2 (hit_reserved == $past(rsv, 2))) else $error("reserved flag");
  a_usb_block: assert property (take |-> ##2 (usb_buffer_blocked == $past(usb, 2))) else $error("usb block flag");
  a_hole_read: assert property (take && !hwrite && rsv |-> ##2 (hrdata[7:0] == 8'h00)) else $error("hole read");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000) else $error("upper read bits");
  a_pullup_gate: assert property (!$past(option_pullup_bit) |-> !port_e_bit5_pullup) else $error("pull-up on");
endmodule : mmd_decoder_checker

// ===== dv/mmd_core_model.sv
// Core-side bus master model issuing single AHB-Lite word transfers
`timescale 1ns/1ps
module mmd_core_model (
  // Clock and slave answer
  input  wire logic        mclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Master request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    {hsel, haddr, htrans, hwrite} = '0;
    hsize = 3'h2;
    hwdata = 32'hFFFFFFFF;
  end
  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {14'h0000, idx, 2'b00};
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata[7:0];
    // Released data lines show the inverse so stale values never pass
    hwdata <= {24'hFFFFFF, ~wd};
  endtask : xfer
endmodule : mmd_core_model

// ===== dv/mmd_decoder_bench.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("Error %0t: got %h want %h", $time, a, b); end end
module mmd_decoder_bench;
  import mmd_pkg::*;
  logic        mclk = 0, rst_b = 0, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        opt_pu = 0, opt_usb = 0, st6 = 0, usb_req = 0;
  logic [7:0]  conv = 8'h5A, cb_out = 8'h3C, cb_oe_b = 8'h00, rd;
  logic [5:0]  ca_out = 6'h15, ca_oe_b = 6'h2A;
  logic [7:0]  pa_out, pa_oe_b, pb_out, pb_oe_b, pf_out, pf_oe_b;
  logic        pu, ce1, ce2, h_reg, h_stk, h_vec, h_rsv, ublk;
  int          bad_count = 0, compares = 0, cycles = 0;
  // Mixed cases, reserved holes and read-only result included: index, written byte, byte read back
  logic [15:0] row_idx [10] = '{16'h0, 16'hE, 16'h12, 16'h13, 16'h5, 16'h19, 16'h14, 16'h1E, 16'h30, 16'h100};
  logic [7:0]  row_wr  [10] = '{8'hA5, 8'hFF, 8'h33, 8'hC3, 8'h77, 8'h3C, 8'h12, 8'h99, 8'h55, 8'h11};
  logic [7:0]  row_exp [10] = '{8'hA5, 8'hFF, 8'h5A, 8'hC3, 8'h00, 8'h3C, 8'h12, 8'h00, 8'h00, 8'h00};
  always #50 mclk = ~mclk;
  assign hready = hreadyout;
  mmd_decoder DUT (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .option_pullup_bit(opt_pu), .option_usb_power(opt_usb), .standalone_6mhz(st6), .converter_result(conv),
    .usb_power_request(usb_req), .coproc_a_out(ca_out), .coproc_a_oe_b(ca_oe_b), .coproc_b_out(cb_out),
    .coproc_b_oe_b(cb_oe_b), .port_a_pin_out(pa_out), .port_a_pin_oe_b(pa_oe_b), .port_b_pin_out(pb_out),
    .port_b_pin_oe_b(pb_oe_b), .port_f_pin_out(pf_out), .port_f_pin_oe_b(pf_oe_b), .port_e_bit5_pullup(pu),
    .card_enable_one(ce1), .card_enable_two(ce2), .hit_register(h_reg), .hit_stack(h_stk), .hit_vector(h_vec),
    .hit_reserved(h_rsv), .usb_buffer_blocked(ublk));
  mmd_core_model core (.mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("Error %0t: run too long", $time);
      finish_test();
    end
  end
  task wr(input logic [15:0] i, input logic [7:0] d); core.xfer(1'b1, i, d, rd); endtask : wr
  task rdr(input logic [15:0] i); core.xfer(1'b0, i, 8'h00, rd); endtask : rdr
  // Pins lag the register by one flop
  task settle; repeat (2) @(posedge mclk); #1; endtask : settle
  task finish_test;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset values; serial data and control slots are skipped, result is live
    for (int i = 0; i < 32; i++) begin
      if (i == 16'h12 || i == 16'h19 || i == 16'h1A) continue;
      rdr(i[15:0]);
      `CHK(rd, (i == 16'h14) ? 8'h7F : 8'h00)
    end
    $display("reset values done");
    for (int r = 0; r < 10; r++) begin
      wr(row_idx[r], row_wr[r]);
      rdr(row_idx[r]);
      `CHK(rd, row_exp[r])
    end
    $display("row table done");
    // Card enables are software pins, coprocessor takes the low lines only
    wr(MMD_PORT_A_DIRECTION, 8'hFF);
    wr(MMD_PORT_A_DATA, 8'h40);
    settle();
    `CHK({ce2, ce1, pa_out}, {2'b01, 8'h40})
    wr(MMD_COPROC_CONTROL, 8'h01);
    settle();
    `CHK({pa_out, pa_oe_b, pb_out, pb_oe_b}, {8'h55, 8'h2A, 8'h3C, 8'h00})
    $display("card lines done");
    // Pull-up needs both the option register and the option byte
    wr(MMD_PORT_E_OPTIONS, 8'h20);
    settle();
    `CHK(pu, 1'b0)
    @(posedge mclk) opt_pu <= 1'b1;
    settle();
    `CHK(pu, 1'b1)
    // Port F bit 4 is plain I/O unless the option byte gives it to USB power
    wr(MMD_PORT_F_DATA, 8'h10);
    wr(MMD_PORT_F_DIRECTION, 8'h10);
    settle();
    `CHK({pf_out[4], pf_oe_b}, {1'b1, 8'hEF})
    @(posedge mclk) opt_usb <= 1'b1;
    settle();
    `CHK({pf_out[4], pf_oe_b}, {1'b0, 8'hEF})
    $display("pin options done");
    // USB buffer blocked in standalone mode, vector area reached
    @(posedge mclk) st6 <= 1'b1;
    rdr(16'h1500);
    `CHK(rd, 8'h00)
    rdr(16'hFFF0);
    `CHK(rd, 8'h00)
    // Second reset in mid-run restores the watchdog value
    @(posedge mclk) rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rdr(MMD_WATCHDOG_CONTROL);
    `CHK(rd, 8'h7F)
    $display("second reset done");
    finish_test();
  end
endmodule : mmd_decoder_bench
bind mmd_decoder mmd_decoder_checker #(.USB_BUF_BASE(USB_BUF_BASE), .USB_BUF_TOP(USB_BUF_TOP)) chk (.mclk(mclk),
  .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .option_pullup_bit(option_pullup_bit), .standalone_6mhz(standalone_6mhz),
  .port_e_bit5_pullup(port_e_bit5_pullup), .hit_register(hit_register), .hit_stack(hit_stack),
  .hit_vector(hit_vector), .hit_reserved(hit_reserved), .usb_buffer_blocked(usb_buffer_blocked));
